// *** logic/drive_monitor.sv ***
/*
 * compares a driven pin value with its feedback once the pin has had time
 * to settle; raises fault_out in every settled cycle in which they differ.
 * assumes feedback is synchronous to clk_in.
 */
`timescale 1ns/10ps
`include "status_cfg.svh"

module drive_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic drive_in,
  input wire logic expected_in,
  input wire logic feedback_in,
  output logic fault_out
);

  logic [`SETTLE_W-1:0] settle_q;
  logic expected_q;
  logic fault_q;
  logic settled;

  assign settled = (settle_q == `SETTLE_W'(`DRIVE_SETTLE_CYC));

  // ==========================================================
  // settle timer restarts whenever the driven value moves
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      settle_q <= '0;
      expected_q <= 1'b0;
    end else begin
      expected_q <= expected_in;
      if (!drive_in || (expected_in != expected_q)) begin
        settle_q <= '0;
      end else if (!settled) begin
        settle_q <= settle_q + `SETTLE_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= drive_in && settled && (feedback_in != expected_q);
    end
  end

  assign fault_out = fault_q;

endmodule

// *** logic/ring_counter.sv ***
/*
 * 16-bit oscillator cycle counter: reset, count fast ticks, count slow
 * ticks, or hold. tick inputs are one-cycle pulses synchronous to clk_in.
 */
`timescale 1ns/10ps
`include "status_cfg.svh"

module ring_counter (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input status_pkg::ring_ctl_e control_in,
  input wire logic fast_tick_in,
  input wire logic slow_tick_in,
  output logic [15:0] tally_out
);
  import status_pkg::*;

  logic [15:0] tally_q;

  // ==========================================================
  // counting wraps naturally at the 16-bit limit
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tally_q <= `OSCILLATOR_CYCLE_MONITOR_RST;
    end else begin
      case (control_in)
        ring_reset: tally_q <= `OSCILLATOR_CYCLE_MONITOR_RST;
        ring_fast: if (fast_tick_in) tally_q <= tally_q + 16'h0001;
        ring_slow: if (slow_tick_in) tally_q <= tally_q + 16'h0001;
        ring_stop: tally_q <= tally_q;
        default: tally_q <= tally_q;
      endcase
    end
  end

  assign tally_out = tally_q;

endmodule

// *** logic/status_cfg.svh ***
/*
 * constants of the system status / test configuration / oscillator monitor
 * register group: register indices, reset values and check timing.
 * assumes a 200 mhz core clock and 7-bit serial register addresses.
 */
`ifndef STATUS_CFG_SVH
`define STATUS_CFG_SVH

// ==========================================================
// register indices as carried in the serial frame
`define ADDR_W 7
`define SYSTEM_STATUS_OFS 7'h0e
`define TEST_CONFIG_OFS 7'h0f
`define OSCILLATOR_CYCLE_MONITOR_OFS 7'h10

// ==========================================================
// reset values
`define SYSTEM_STATUS_RST 16'h0000
`define OSCILLATOR_CYCLE_MONITOR_RST 16'h0000
`define TEST_RSVD_HI_RST 10'h001
`define TEST_RSVD_LO_RST 1'h0
`define CHECK_DISABLE_RST 1'h0
`define UNMAPPED_READ 16'h0000
`define REVISION_DEFAULT 2'h0

// ==========================================================
// pin feedback check timing
`define CLK_PERIOD_NS 5
`define DRIVE_SETTLE_NS 50
`define DRIVE_SETTLE_CYC ((`DRIVE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_W 4

// ==========================================================
// flag vector layout
`define FLAG_COUNT 10

`endif

// *** logic/status_pkg.sv ***
/*
 * types of the status register group: operating states, counter control
 * codes, interrupt cause codes and the two register word layouts.
 * assumes status_cfg.svh is included by the modules that need numbers.
 */
`include "status_cfg.svh"

package status_pkg;

  // ==========================================================
  // operating state as reported by the mode controller
  typedef enum logic [2:0] {
    op_config,
    op_standby,
    op_active_continuous,
    op_active_triggered,
    op_duty_cycled_active,
    op_duty_cycled_sleep,
    op_sleep
  } op_state_e;

  typedef enum logic [1:0] {
    ring_reset,
    ring_fast,
    ring_slow,
    ring_stop
  } ring_ctl_e;

  typedef enum logic [1:0] {
    cause_none,
    cause_afe,
    cause_sys,
    cause_both
  } cause_e;

  // ==========================================================
  // register word layouts, msb first
  typedef struct packed {
    logic interrupt_pin_level;
    logic interrupt_drive_fault;
    logic serial_out_drive_fault;
    logic check_error;
    logic frame_error;
    logic [2:0] op_state;
    logic [1:0] reserved;
    logic supply_over_flag;
    logic supply_under_flag;
    logic thermal_cross_flag;
    logic z_cross_flag;
    logic y_cross_flag;
    logic x_cross_flag;
  } system_status_s;

  typedef struct packed {
    logic [9:0] reserved_hi;
    logic [1:0] silicon_revision;
    logic reserved_lo;
    logic check_disable;
    ring_ctl_e ring_counter_control;
  } test_config_s;

  // access from the serial frame engine
  typedef struct packed {
    logic read;
    logic write;
    logic [`ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

  // events reported by the surrounding device logic
  typedef struct packed {
    logic check_error;
    logic frame_error;
    logic supply_over;
    logic supply_under;
    logic thermal_cross;
    logic z_cross;
    logic y_cross;
    logic x_cross;
  } event_s;

endpackage

// *** logic/system_status_oscillator_cycle_monitor_regs.sv ***
/*
 * system status, test configuration and oscillator monitor registers.
 * register reads and writes come from the serial frame engine as one-cycle
 * strobes with an address; read data is valid the cycle after the strobe.
 * link faults, supply and threshold events arrive as one-cycle pulses.
 * the alert pin is open drain: out, enable and feedback.
 */
`timescale 1ns/10ps
`include "status_cfg.svh"

module system_status_oscillator_cycle_monitor_regs #(
  parameter logic [1:0] SILICON_REVISION = `REVISION_DEFAULT // arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input status_pkg::reg_req_s req_in,
  output logic [15:0] read_data_out,
  output logic read_valid_out,
  input status_pkg::event_s event_in,
  input status_pkg::op_state_e op_state_in,
  input wire logic afe_flag_any_in,
  input wire logic alert_request_in,
  input wire logic alert_pin_in,
  output logic alert_pin_out,
  output logic alert_pin_oe_out,
  input wire logic sdo_drive_in,
  input wire logic sdo_value_in,
  input wire logic sdo_pin_in,
  input wire logic fast_tick_in,
  input wire logic slow_tick_in,
  output logic check_disable_out,
  output status_pkg::cause_e interrupt_cause_out
);
  import status_pkg::*;

  // ==========================================================
  // declarations
  logic [`FLAG_COUNT-1:0] flag_q;
  logic [`FLAG_COUNT-1:0] flag_set;
  logic interrupt_drive_event;
  logic serial_out_drive_event;
  logic supply_window;
  logic status_read;
  logic sys_any;
  logic level_q;
  logic [15:0] read_data_q;
  logic read_valid_q;
  logic [15:0] tally;
  cause_e cause_q;
  logic check_disable_q;
  ring_ctl_e ring_control_q;
  system_status_s status_word;
  test_config_s test_word;
  test_config_s write_word;
  logic sel_status;
  logic sel_test;
  logic sel_monitor;
  logic test_write;
  logic check_enabled;
  logic [15:0] read_mux;

  // ==========================================================
  // alert pin: open drain, only ever pulls low
  assign alert_pin_out = 1'b0;
  assign alert_pin_oe_out = alert_request_in;

  // the sensed level is registered so the read path never sees a raw pin
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_q <= 1'b0;
    end else begin
      level_q <= alert_pin_in;
    end
  end

  // ==========================================================
  // pin feedback checks
  // while alert is driven the pin must read low after settling
  drive_monitor alert_check (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .drive_in(alert_request_in),
    .expected_in(1'b0),
    .feedback_in(alert_pin_in),
    .fault_out(interrupt_drive_event)
  );

  // serial output compared bit by bit while the device drives it
  drive_monitor sdo_check (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .drive_in(sdo_drive_in),
    .expected_in(sdo_value_in),
    .feedback_in(sdo_pin_in),
    .fault_out(serial_out_drive_event)
  );

  // ==========================================================
  // event collection
  // supply checks only count in standby or an active mode
  always_comb begin
    case (op_state_in)
      op_standby: supply_window = 1'b1;
      op_active_continuous: supply_window = 1'b1;
      op_active_triggered: supply_window = 1'b1;
      op_duty_cycled_active: supply_window = 1'b1;
      op_config: supply_window = 1'b0;
      op_duty_cycled_sleep: supply_window = 1'b0;
      op_sleep: supply_window = 1'b0;
      default: supply_window = 1'b0;
    endcase
  end

  // with check codes off the link engine may still report a mismatch; ignore it
  assign check_enabled = !check_disable_q;

  always_comb begin
    flag_set[9] = interrupt_drive_event;
    flag_set[8] = serial_out_drive_event;
    flag_set[7] = event_in.check_error && check_enabled;
    flag_set[6] = event_in.frame_error;
    flag_set[5] = event_in.supply_over && supply_window;
    flag_set[4] = event_in.supply_under && supply_window;
    flag_set[3] = event_in.thermal_cross;
    flag_set[2] = event_in.z_cross;
    flag_set[1] = event_in.y_cross;
    flag_set[0] = event_in.x_cross;
  end

  // ==========================================================
  // address decode shared by the read and write paths
  assign sel_status = (req_in.addr == `SYSTEM_STATUS_OFS);
  assign sel_test = (req_in.addr == `TEST_CONFIG_OFS);
  assign sel_monitor = (req_in.addr == `OSCILLATOR_CYCLE_MONITOR_OFS);
  assign test_write = req_in.write && sel_test;
  assign status_read = req_in.read && sel_status;

  // ==========================================================
  // sticky flags; a new event in the read cycle survives the clear
  generate
    for (genvar i = 0; i < `FLAG_COUNT; i++) begin : g_flag
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          flag_q[i] <= 1'b0;
        end else if (flag_set[i]) begin
          flag_q[i] <= 1'b1;
        end else if (status_read) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // system status word assembly
  always_comb begin
    status_word = system_status_s'(`SYSTEM_STATUS_RST);
    status_word.interrupt_pin_level = level_q;
    status_word.interrupt_drive_fault = flag_q[9];
    status_word.serial_out_drive_fault = flag_q[8];
    status_word.check_error = flag_q[7];
    status_word.frame_error = flag_q[6];
    status_word.op_state = op_state_in;
    status_word.supply_over_flag = flag_q[5];
    status_word.supply_under_flag = flag_q[4];
    status_word.thermal_cross_flag = flag_q[3];
    status_word.z_cross_flag = flag_q[2];
    status_word.y_cross_flag = flag_q[1];
    status_word.x_cross_flag = flag_q[0];
  end

  // ==========================================================
  // test configuration: only the check and counter fields are writable
  assign write_word = test_config_s'(req_in.wdata);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      check_disable_q <= `CHECK_DISABLE_RST;
    end else if (test_write) begin
      check_disable_q <= write_word.check_disable;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ring_control_q <= ring_reset;
    end else if (test_write) begin
      ring_control_q <= write_word.ring_counter_control;
    end
  end

  // reserved and revision bits are not stored, so no write can reach them
  always_comb begin
    test_word.reserved_hi = `TEST_RSVD_HI_RST;
    test_word.silicon_revision = SILICON_REVISION;
    test_word.reserved_lo = `TEST_RSVD_LO_RST;
    test_word.check_disable = check_disable_q;
    test_word.ring_counter_control = ring_control_q;
  end

  assign check_disable_out = check_disable_q;

  // ==========================================================
  // oscillator cycle counter
  ring_counter ring_cycle_tally (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .control_in(ring_control_q),
    .fast_tick_in(fast_tick_in),
    .slow_tick_in(slow_tick_in),
    .tally_out(tally)
  );

  // ==========================================================
  // read path: word chosen here, registered one cycle after the strobe
  // the status value returned is the one before the clear
  always_comb begin
    if (sel_status) begin
      read_mux = status_word;
    end else if (sel_test) begin
      read_mux = test_word;
    end else if (sel_monitor) begin
      read_mux = tally;
    end else begin
      read_mux = `UNMAPPED_READ;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      read_data_q <= `UNMAPPED_READ;
    end else if (req_in.read) begin
      read_data_q <= read_mux;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      read_valid_q <= 1'b0;
    end else begin
      read_valid_q <= req_in.read;
    end
  end

  assign read_data_out = read_data_q;
  assign read_valid_out = read_valid_q;

  // ==========================================================
  // alert response summary for the conversion status word
  assign sys_any = |flag_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cause_q <= cause_none;
    end else begin
      case ({sys_any, afe_flag_any_in})
        2'b11: cause_q <= cause_both;
        2'b10: cause_q <= cause_sys;
        2'b01: cause_q <= cause_afe;
        default: cause_q <= cause_none;
      endcase
    end
  end

  assign interrupt_cause_out = cause_q;

endmodule

// *** sim/serial_host_model.sv ***
/*
 * behavioural serial frame engine seen from the register group: one-cycle
 * read and write strobes. assumes the test top calls rd and wr in turn.
 */
`timescale 1ns/10ps
`include "status_cfg.svh"

module serial_host_model (
  input wire logic clk_in,
  input wire logic [15:0] read_data_in,
  input wire logic read_valid_in,
  output status_pkg::reg_req_s req_out
);
  import status_pkg::*;
  initial req_out = '0;
  // ==========================================================
  // transfers; address is scrambled after each one, and write data after each wr, so stale values never look valid
  task automatic rd(input logic [6:0] a, output logic [16:0] r);
    @(posedge clk_in);
    #1;
    req_out.read = 1'b1;
    req_out.addr = a;
    @(posedge clk_in);
    #1;
    req_out.read = 1'b0;
    req_out.addr = ~a;
    r = {read_valid_in, read_data_in};
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    req_out.write = 1'b1;
    req_out.addr = a;
    req_out.wdata = d;
    @(posedge clk_in);
    #1;
    req_out.write = 1'b0;
    req_out.addr = ~a;
    req_out.wdata = ~d;
  endtask
endmodule

// *** sim/system_status_oscillator_cycle_monitor_regs_test.sv ***
/*
 * self-checking bench of the status register group with a frame engine model.
 * assumes the default revision parameter and a pulled-up alert line.
 */
`timescale 1ns/10ps
`include "status_cfg.svh"

module system_status_oscillator_cycle_monitor_regs_test;
  import status_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  reg_req_s req_in;
  logic [15:0] read_data_out;
  logic read_valid_out;
  event_s event_in = '0;
  op_state_e op_state_in = op_config;
  logic afe_flag_any_in = 1'b0;
  logic alert_request_in = 1'b0;
  logic alert_pin_in;
  logic alert_pin_out;
  logic alert_pin_oe_out;
  logic sdo_drive_in = 1'b0;
  logic sdo_value_in = 1'b0;
  logic sdo_pin_in;
  logic fast_tick_in = 1'b0;
  logic slow_tick_in = 1'b0;
  logic check_disable_out;
  cause_e interrupt_cause_out;
  logic stuck = 1'b0;
  logic brk = 1'b0;
  int n_mismatch = 0;
  int checked = 0;
  always #2.5 clk_in = ~clk_in;
  // pull-up wins unless a party drives low; stuck models a broken pin
  assign alert_pin_in = (alert_pin_oe_out && !stuck) ? alert_pin_out : 1'b1;
  assign sdo_pin_in = sdo_drive_in ? sdo_value_in ^ brk : ~sdo_value_in;
  system_status_oscillator_cycle_monitor_regs system_status_oscillator_cycle_monitor_regs_inst (.clk_in, .rst_n_in, .req_in, .read_data_out,
    .read_valid_out, .event_in, .op_state_in, .afe_flag_any_in, .alert_request_in, .alert_pin_in,
    .alert_pin_out, .alert_pin_oe_out, .sdo_drive_in, .sdo_value_in, .sdo_pin_in, .fast_tick_in,
    .slow_tick_in, .check_disable_out, .interrupt_cause_out);
  serial_host_model serial_host_model_inst (.clk_in(clk_in), .read_data_in(read_data_out),
    .read_valid_in(read_valid_out), .req_out(req_in));
  // ==========================================================
  // helpers
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input string n, input logic [6:0] a, input logic [15:0] e);
    logic [16:0] r;
    serial_host_model_inst.rd(a, r);
    chk(n, {1'b1, e}, r);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic pulse(input logic [7:0] e);
    event_in = e;
    cyc(1);
    event_in = '0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rdc("status", `SYSTEM_STATUS_OFS, 16'h8000);
    rdc("test_config", `TEST_CONFIG_OFS, 16'h0040);
    rdc("monitor", `OSCILLATOR_CYCLE_MONITOR_OFS, `OSCILLATOR_CYCLE_MONITOR_RST);
    rdc("unmapped", 7'h11, `UNMAPPED_READ);
  endtask
  task automatic t_flags();
    op_state_in = op_standby;
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      cyc(2);
      chk("cause", {15'h0, cause_sys}, {15'h0, interrupt_cause_out});
      rdc("flag", `SYSTEM_STATUS_OFS, 16'h8100 | (16'h1 << (i < 6 ? i : i + 5)));
      rdc("cleared", `SYSTEM_STATUS_OFS, 16'h8100);
    end
    afe_flag_any_in = 1'b1;
    cyc(2);
    chk("cause_afe", {15'h0, cause_afe}, {15'h0, interrupt_cause_out});
    pulse(8'h08);
    cyc(2);
    chk("cause_both", {15'h0, cause_both}, {15'h0, interrupt_cause_out});
    afe_flag_any_in = 1'b0;
    rdc("thermal", `SYSTEM_STATUS_OFS, 16'h8108);
  endtask
  task automatic t_gate();
    op_state_e sl[3] = '{op_config, op_duty_cycled_sleep, op_sleep};
    for (int j = 0; j < 3; j++) begin
      op_state_in = sl[j];
      pulse(8'h30);
      rdc("supply_gated", `SYSTEM_STATUS_OFS, 16'h8000 | {5'h0, sl[j], 8'h0});
    end
    for (int k = 0; k < 7; k++) begin
      op_state_in = op_state_e'(k);
      rdc("op_state", `SYSTEM_STATUS_OFS, 16'h8000 | (16'(k) << 8));
    end
    op_state_in = op_config;
  endtask
  task automatic t_config();
    serial_host_model_inst.wr(`TEST_CONFIG_OFS, 16'hfffc);
    chk("check_disable", 17'h1, {16'h0, check_disable_out});
    rdc("test_config", `TEST_CONFIG_OFS, 16'h0044);
    pulse(8'h80);
    rdc("check_masked", `SYSTEM_STATUS_OFS, 16'h8000);
    serial_host_model_inst.wr(`SYSTEM_STATUS_OFS, 16'hffff);
    serial_host_model_inst.wr(`OSCILLATOR_CYCLE_MONITOR_OFS, 16'hffff);
    serial_host_model_inst.wr(`TEST_CONFIG_OFS, 16'h0000);
    rdc("ro_writes", `SYSTEM_STATUS_OFS, 16'h8000);
    pulse(8'h80);
    rdc("check_on", `SYSTEM_STATUS_OFS, 16'h9000);
  endtask
  task automatic ticks(input logic f, input logic s, input int n);
    fast_tick_in = f;
    slow_tick_in = s;
    cyc(n);
    fast_tick_in = 1'b0;
    slow_tick_in = 1'b0;
  endtask
  task automatic t_counter();
    serial_host_model_inst.wr(`TEST_CONFIG_OFS, 16'h0001);
    ticks(1'b0, 1'b0, 1);
    ticks(1'b1, 1'b1, 5);
    serial_host_model_inst.wr(`TEST_CONFIG_OFS, 16'h0003);
    ticks(1'b1, 1'b1, 4);
    rdc("fast_held", `OSCILLATOR_CYCLE_MONITOR_OFS, 16'h0005);
    serial_host_model_inst.wr(`TEST_CONFIG_OFS, 16'h0000);
    rdc("cleared", `OSCILLATOR_CYCLE_MONITOR_OFS, 16'h0000);
    serial_host_model_inst.wr(`TEST_CONFIG_OFS, 16'h0002);
    ticks(1'b0, 1'b0, 1);
    ticks(1'b1, 1'b1, 3);
    serial_host_model_inst.wr(`TEST_CONFIG_OFS, 16'h0003);
    rdc("slow", `OSCILLATOR_CYCLE_MONITOR_OFS, 16'h0003);
    serial_host_model_inst.wr(`TEST_CONFIG_OFS, 16'h0000);
    serial_host_model_inst.wr(`TEST_CONFIG_OFS, 16'h0001);
    ticks(1'b0, 1'b0, 1);
    ticks(1'b1, 1'b0, 65537);
    serial_host_model_inst.wr(`TEST_CONFIG_OFS, 16'h0003);
    rdc("wrapped", `OSCILLATOR_CYCLE_MONITOR_OFS, 16'h0001);
  endtask
  task automatic t_drive();
    stuck = 1'b1;
    alert_request_in = 1'b1;
    cyc(15);
    alert_request_in = 1'b0;
    rdc("alert_fault", `SYSTEM_STATUS_OFS, 16'hc000);
    stuck = 1'b0;
    alert_request_in = 1'b1;
    cyc(15);
    rdc("alert_low", `SYSTEM_STATUS_OFS, 16'h0000);
    alert_request_in = 1'b0;
    sdo_drive_in = 1'b1;
    sdo_value_in = 1'b1;
    brk = 1'b1;
    cyc(15);
    sdo_drive_in = 1'b0;
    rdc("sdo_fault", `SYSTEM_STATUS_OFS, 16'ha000);
    brk = 1'b0;
    sdo_drive_in = 1'b1;
    cyc(15);
    sdo_drive_in = 1'b0;
    rdc("sdo_ok", `SYSTEM_STATUS_OFS, 16'h8000);
  endtask
  // ==========================================================
  // main sequence and hang guard
  initial begin
    repeat (5) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    t_reset();
    t_flags();
    t_gate();
    t_config();
    t_counter();
    t_drive();
    final_report();
  end
  initial begin
    #450000;
    n_mismatch++;
    final_report();
  end
endmodule

bind system_status_oscillator_cycle_monitor_regs system_status_regs_properties props_inst (.clk_in, .rst_n_in, .req_in,
  .read_data_out, .read_valid_out, .op_state_in, .afe_flag_any_in, .alert_request_in, .alert_pin_in,
  .alert_pin_out, .alert_pin_oe_out, .check_disable_out, .interrupt_cause_out);

// *** sim/system_status_regs_properties.sv ***
/*
 * properties on the ports of the status register group.
 * assumes the default revision parameter and a bind from the test top.
 */
`timescale 1ns/10ps
`include "status_cfg.svh"

module system_status_regs_properties (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input status_pkg::reg_req_s req_in,
  input wire logic [15:0] read_data_out,
  input wire logic read_valid_out,
  input status_pkg::op_state_e op_state_in,
  input wire logic afe_flag_any_in,
  input wire logic alert_request_in,
  input wire logic alert_pin_in,
  input wire logic alert_pin_out,
  input wire logic alert_pin_oe_out,
  input wire logic check_disable_out,
  input status_pkg::cause_e interrupt_cause_out
);
  import status_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic rd_st;
  logic rd_tc;
  logic rd_un;
  logic wr_tc;
  logic cause_afe_bit;
  logic [12:0] tc_fixed;
  assign rd_st = req_in.read && req_in.addr == `SYSTEM_STATUS_OFS;
  assign rd_tc = req_in.read && req_in.addr == `TEST_CONFIG_OFS;
  assign rd_un = req_in.read && !rd_st && !rd_tc && req_in.addr != `OSCILLATOR_CYCLE_MONITOR_OFS;
  assign wr_tc = req_in.write && req_in.addr == `TEST_CONFIG_OFS;
  assign cause_afe_bit = interrupt_cause_out inside {cause_afe, cause_both};
  assign tc_fixed = {`TEST_RSVD_HI_RST, `REVISION_DEFAULT, `TEST_RSVD_LO_RST};
  // ==========================================================
  // assertions
  AST_READ_ANSWER: assert property (read_valid_out == ($past(req_in.read) && $past(rst_n_in)))
    else $error("read answer not one cycle after strobe");
  AST_OPEN_DRAIN: assert property (alert_pin_out == 1'b0 && alert_pin_oe_out == alert_request_in)
    else $error("alert pin not driven low on request");
  AST_PIN_LEVEL: assert property (rd_st && $past(rst_n_in) |=> read_data_out[15] == $past(alert_pin_in, 2))
    else $error("status pin level wrong");
  AST_OP_STATE: assert property (rd_st |=> read_data_out[10:8] == $past(op_state_in))
    else $error("status operating state wrong");
  AST_REVISION: assert property (rd_tc |=> read_data_out[15:3] == tc_fixed)
    else $error("test config fixed bits wrong");
  AST_CHECK_BIT: assert property (rd_tc && !req_in.write |=> read_data_out[2] == $past(check_disable_out))
    else $error("check disable readback wrong");
  AST_WRITE_CHECK: assert property (wr_tc |=> check_disable_out == $past(req_in.wdata[2]))
    else $error("check disable not written");
  AST_UNMAPPED: assert property (rd_un |=> read_data_out == `UNMAPPED_READ)
    else $error("unmapped read not zero");
  AST_AFE_CAUSE: assert property ($past(rst_n_in) |-> cause_afe_bit == $past(afe_flag_any_in))
    else $error("interrupt cause analog bit wrong");
  AST_DATA_HOLD: assert property (!req_in.read |=> $stable(read_data_out))
    else $error("read data changed without read");
endmodule
